/* logic/qdr_defines.vh */
// Constants for the multi-line read controller: opcodes, field layouts, timing.
// Included by the controller; holds definitions only.
`ifndef QDR_DEFINES_VH
`define QDR_DEFINES_VH
// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define QDR_OP_QUAD_OUT      8'h6b
`define QDR_OP_QUAD_OUT_WIDE 8'h6c
`define QDR_OP_DUAL_IO       8'hbb
`define QDR_OP_DUAL_IO_WIDE  8'hbc
// ----------------------------------------------------------------
// Mode byte
// ----------------------------------------------------------------
`define QDR_MODE_CONT_NIB    4'ha
`define QDR_MODE_EXIT        8'hff
// ----------------------------------------------------------------
// Host registers (word index == address)
// ----------------------------------------------------------------
`define QDR_REG_CTRL         4'h0
`define QDR_REG_ADDR         4'h1
`define QDR_REG_CONFIG       4'h2
`define QDR_REG_STATUS       4'h3
`define QDR_REG_DATA         4'h4
`define QDR_REG_COUNT        4'h5
// Control register fields
`define QDR_CTRL_START_BIT   0
`define QDR_CTRL_DUAL_BIT    1
`define QDR_CTRL_WIDE_BIT    2
`define QDR_CTRL_CONT_BIT    3
`define QDR_CTRL_ABORT_BIT   4
// Configuration register fields
`define QDR_CFG_EXTADDR_BIT  0
`define QDR_CFG_QUAD_EN_BIT  1
`define QDR_CFG_ENH_BIT      2
`define QDR_CFG_DUMMY_LSB    4
`define QDR_CFG_DUMMY_W      4
`define QDR_CFG_RESET        8'h00
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define QDR_SCK_HALF_DIV     4'h3
`define QDR_ABORT_CLKS       4'h4
`endif

/* logic/qdr_host.v */
// Host controller for quad output read and dual I/O read of a serial flash.
// Assumes a single system clock; flash I/O returns pass a two-stage sync.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "qdr_defines.vh"

module qdr_host #(
  parameter SCK_HALF = `QDR_SCK_HALF_DIV
) (
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire [3:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output wire [31:0] rdata_o,
  output wire        busy_o,
  output wire        cs_n_o,
  output wire        sck_o,
  output wire [3:0]  io_o,
  output wire [3:0]  io_oe_o,
  input  wire [3:0]  io_i
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_OPC   = 3'h1;
  localparam [2:0] ST_ADDR  = 3'h2;
  localparam [2:0] ST_MODE  = 3'h3;
  localparam [2:0] ST_DUMMY = 3'h4;
  localparam [2:0] ST_DATA  = 3'h5;
  localparam [2:0] ST_ABORT = 3'h6;
  localparam [2:0] ST_GAP   = 3'h7;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [2:0]  state_reg;
  reg [3:0]  div_reg;
  reg        sck_reg;
  reg        cs_n_reg;
  reg [3:0]  io_reg;
  reg [3:0]  oe_reg;
  reg [31:0] rdata_reg;
  reg        busy_reg;
  reg [7:0]  cfg_reg;
  reg [31:0] addr_reg;
  reg        dual_reg;
  reg        wide_reg;
  reg        cont_req_reg;
  reg        cont_mode_reg;
  reg [39:0] shift_reg;
  reg [5:0]  bits_reg;
  reg [3:0]  dummy_reg;
  reg [7:0]  byte_reg;
  reg [2:0]  bcnt_reg;
  reg [7:0]  data_reg;
  reg        data_new_reg;
  reg        err_reg;
  reg [15:0] count_reg;
  reg [3:0]  io_s1_reg;
  reg [3:0]  io_s2_reg;

  wire       tick  = (div_reg == SCK_HALF);
  wire       rise  = tick & ~sck_reg;
  wire       fall  = tick & sck_reg;
  wire [3:0] dummy_cfg = cfg_reg[`QDR_CFG_DUMMY_LSB +: `QDR_CFG_DUMMY_W];
  wire       enh   = cfg_reg[`QDR_CFG_ENH_BIT];
  wire [2:0] lanes = dual_reg ? 3'h2 : 3'h1;

  assign rdata_o = rdata_reg;
  assign busy_o  = busy_reg;
  assign cs_n_o  = cs_n_reg;
  assign sck_o   = sck_reg;
  assign io_o    = io_reg;
  assign io_oe_o = oe_reg;

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  // Returned data is asynchronous to this clock, so two stages first
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      io_s1_reg <= 4'h0;
      io_s2_reg <= 4'h0;
    end else begin
      io_s1_reg <= io_i;
      io_s2_reg <= io_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Read data stands the cycle after the strobe; reading DATA clears its flag
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0;
    end else if (rd_i) begin
      if (addr_i == `QDR_REG_ADDR) begin
        rdata_reg <= addr_reg;
      end else if (addr_i == `QDR_REG_CONFIG) begin
        rdata_reg <= {24'h0, cfg_reg};
      end else if (addr_i == `QDR_REG_STATUS) begin
        rdata_reg <= {24'h0, 1'b0, state_reg, err_reg, cont_mode_reg, data_new_reg, busy_reg};
      end else if (addr_i == `QDR_REG_DATA) begin
        rdata_reg <= {24'h0, data_reg};
      end else if (addr_i == `QDR_REG_COUNT) begin
        rdata_reg <= {16'h0, count_reg};
      end else begin
        rdata_reg <= 32'h0;
      end
    end else begin
      rdata_reg <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  // One process owns the frame so the clock phase and data phase never disagree
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg     <= ST_IDLE;
      div_reg       <= 4'h0;
      sck_reg       <= 1'b0;
      cs_n_reg      <= 1'b1;
      io_reg        <= 4'h0;
      oe_reg        <= 4'h0;
      busy_reg      <= 1'b0;
      cfg_reg       <= `QDR_CFG_RESET;
      addr_reg      <= 32'h0;
      dual_reg      <= 1'b0;
      wide_reg      <= 1'b0;
      cont_req_reg  <= 1'b0;
      cont_mode_reg <= 1'b0;
      shift_reg     <= 40'h0;
      bits_reg      <= 6'h0;
      dummy_reg     <= 4'h0;
      byte_reg      <= 8'h0;
      bcnt_reg      <= 3'h0;
      data_reg      <= 8'h0;
      data_new_reg  <= 1'b0;
      err_reg       <= 1'b0;
      count_reg     <= 16'h0;
    end else begin
      // Data flag: a new byte wins over a read that clears it
      if (rd_i && addr_i == `QDR_REG_DATA) begin
        data_new_reg <= 1'b0;
      end
      if (state_reg == ST_IDLE) begin
        div_reg <= 4'h0;
      end else if (tick) begin
        div_reg <= 4'h0;
      end else begin
        div_reg <= div_reg + 4'h1;
      end
      case (state_reg)
        ST_IDLE: begin
          sck_reg <= 1'b0;
          if (wr_i && addr_i == `QDR_REG_CONFIG) begin
            cfg_reg <= wdata_i[7:0];
          end else if (wr_i && addr_i == `QDR_REG_ADDR) begin
            addr_reg <= wdata_i;
          end else if (wr_i && addr_i == `QDR_REG_CTRL && wdata_i[`QDR_CTRL_ABORT_BIT]) begin
            // Short frame with no valid opcode releases continuous mode
            state_reg     <= ST_ABORT;
            busy_reg      <= 1'b1;
            cs_n_reg      <= 1'b0;
            oe_reg        <= 4'hf;
            io_reg        <= 4'hf;
            bits_reg      <= {2'h0, `QDR_ABORT_CLKS};
            cont_mode_reg <= 1'b0;
          end else if (wr_i && addr_i == `QDR_REG_CTRL && wdata_i[`QDR_CTRL_START_BIT]) begin
            dual_reg     <= wdata_i[`QDR_CTRL_DUAL_BIT];
            wide_reg     <= wdata_i[`QDR_CTRL_WIDE_BIT];
            cont_req_reg <= wdata_i[`QDR_CTRL_CONT_BIT];
            count_reg    <= wdata_i[31:16];
            err_reg      <= 1'b0;
            if (!wdata_i[`QDR_CTRL_DUAL_BIT] && !cfg_reg[`QDR_CFG_QUAD_EN_BIT]) begin
              err_reg <= 1'b1; // Quad lines unusable until enabled
            end else if (wdata_i[`QDR_CTRL_DUAL_BIT] && cont_mode_reg) begin
              // Continuing frame starts straight at the address
              state_reg <= ST_ADDR;
              busy_reg  <= 1'b1;
              cs_n_reg  <= 1'b0;
              oe_reg    <= 4'h3;
              shift_reg <= (wdata_i[`QDR_CTRL_WIDE_BIT] || cfg_reg[`QDR_CFG_EXTADDR_BIT])
                         ? {addr_reg, 8'h0} : {addr_reg[23:0], 16'h0};
              bits_reg  <= (wdata_i[`QDR_CTRL_WIDE_BIT] || cfg_reg[`QDR_CFG_EXTADDR_BIT])
                         ? 6'd32 : 6'd24;
            end else begin
              state_reg     <= ST_OPC;
              busy_reg      <= 1'b1;
              cs_n_reg      <= 1'b0;
              oe_reg        <= 4'h1;
              cont_mode_reg <= 1'b0;
              bits_reg      <= 6'd8;
              shift_reg     <= {wdata_i[`QDR_CTRL_DUAL_BIT]
                  ? (wdata_i[`QDR_CTRL_WIDE_BIT] ? `QDR_OP_DUAL_IO_WIDE : `QDR_OP_DUAL_IO)
                  : (wdata_i[`QDR_CTRL_WIDE_BIT] ? `QDR_OP_QUAD_OUT_WIDE : `QDR_OP_QUAD_OUT),
                  32'h0};
            end
          end
        end
        ST_OPC, ST_ADDR, ST_MODE: begin
          if (rise) begin
            sck_reg <= 1'b1; // Device samples on this rising edge
          end else if (fall) begin
            sck_reg <= 1'b0;
          end
          // Lines follow the shifter only while the clock is low, so they are
          // settled well before the rising edge that samples them, MSB first
          if (!sck_reg && !rise) begin
            if (state_reg == ST_OPC || !dual_reg) begin
              io_reg <= {3'h0, shift_reg[39]};
            end else begin
              io_reg <= {2'h0, shift_reg[39:38]}; // Two bits a clock
            end
          end
          // The bits just sampled leave the shifter at the rising edge
          if (rise) begin
            if (state_reg == ST_OPC || !dual_reg) begin
              shift_reg <= {shift_reg[38:0], 1'b0};
              bits_reg  <= bits_reg - 6'h1;
            end else begin
              shift_reg <= {shift_reg[37:0], 2'h0};
              bits_reg  <= bits_reg - 6'h2;
            end
          end
          if (fall && bits_reg == 6'h0) begin
            if (state_reg == ST_OPC) begin
              // Address width of a legacy opcode follows extended-address bit
              state_reg <= ST_ADDR;
              oe_reg    <= dual_reg ? 4'h3 : 4'h1;
              shift_reg <= (wide_reg || cfg_reg[`QDR_CFG_EXTADDR_BIT])
                         ? {addr_reg, 8'h0} : {addr_reg[23:0], 16'h0};
              bits_reg  <= (wide_reg || cfg_reg[`QDR_CFG_EXTADDR_BIT]) ? 6'd32 : 6'd24;
            end else if (state_reg == ST_ADDR && dual_reg && enh) begin
              // Enhanced table adds four mode clocks
              state_reg <= ST_MODE;
              shift_reg <= {cont_req_reg ? {`QDR_MODE_CONT_NIB, 4'h0} : `QDR_MODE_EXIT, 32'h0};
              bits_reg  <= 6'd8;
            end else begin
              // No mode clocks on the basic table or quad read
              state_reg <= ST_DUMMY;
              dummy_reg <= dummy_cfg;
              oe_reg    <= 4'h0; // Release before device drives
            end
            if (state_reg == ST_MODE) begin
              // Device keeps or drops continuous mode by this byte
              cont_mode_reg <= cont_req_reg;
            end
            if (state_reg != ST_OPC && !(state_reg == ST_ADDR && dual_reg && enh)) begin
              if (dummy_cfg == 4'h0) begin
                state_reg <= ST_DATA;
                bcnt_reg  <= 3'h0;
              end
            end
          end
          if (state_reg == ST_MODE && fall && bits_reg == 6'd4) begin
            oe_reg <= 4'h0; // Low nibble left undriven
          end
        end
        ST_DUMMY: begin
          // Select held low through dummy clocks
          if (rise) begin
            sck_reg <= 1'b1;
          end else if (fall) begin
            sck_reg   <= 1'b0;
            dummy_reg <= dummy_reg - 4'h1;
            if (dummy_reg == 4'h1) begin
              state_reg <= ST_DATA;
              bcnt_reg  <= 3'h0;
            end
          end
        end
        ST_DATA: begin
          // Sample on the rising edge; device changed data at the fall
          if (rise) begin
            sck_reg <= 1'b1;
            if (dual_reg) begin
              byte_reg <= {byte_reg[5:0], io_s2_reg[1:0]};
            end else begin
              byte_reg <= {byte_reg[3:0], io_s2_reg};
            end
            if (bcnt_reg + lanes == 3'h0 || (bcnt_reg == 3'h4 && !dual_reg)
                || (bcnt_reg == 3'h6 && dual_reg)) begin
              // Byte complete; address advances, wrap is the device's
              data_reg     <= dual_reg ? {byte_reg[5:0], io_s2_reg[1:0]}
                                       : {byte_reg[3:0], io_s2_reg};
              data_new_reg <= 1'b1;
              addr_reg     <= addr_reg + 32'h1;
              count_reg    <= count_reg - 16'h1;
              bcnt_reg     <= 3'h0;
            end else begin
              bcnt_reg <= bcnt_reg + (dual_reg ? 3'h2 : 3'h4);
            end
          end else if (fall) begin
            sck_reg <= 1'b0;
            if (count_reg == 16'h0) begin
              state_reg <= ST_GAP;
              cs_n_reg  <= 1'b1;
            end
          end
        end
        ST_ABORT: begin
          if (rise) begin
            sck_reg <= 1'b1;
          end else if (fall) begin
            sck_reg  <= 1'b0;
            bits_reg <= bits_reg - 6'h1;
            if (bits_reg == 6'h1) begin
              state_reg <= ST_GAP;
              cs_n_reg  <= 1'b1;
              oe_reg    <= 4'h0;
            end
          end
        end
        default: begin
          // Deselect time before the next frame
          sck_reg <= 1'b0;
          oe_reg  <= 4'h0;
          if (fall || rise) begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
          end
        end
      endcase
    end
  end

endmodule

/* verification/qdr_flash_model.sv */
// Behavioural serial flash answering the two multi-line reads.
// Config inputs mirror what the bench wrote into the host.
`timescale 1ns/1ps
module qdr_flash_model (
  input  wire logic       cs_n_i,
  input  wire logic       sck_i,
  input  wire logic [3:0] io_i,
  input  wire logic       ext_addr_i,
  input  wire logic       quad_en_i,
  input  wire logic       enh_i,
  input  wire logic [3:0] dummy_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe_o
);
  // ----------------------------------------------------------------
  // Frame decoder
  // ----------------------------------------------------------------
  logic [7:0]  op_reg, mode_reg;
  logic [31:0] adr_reg;
  logic        cont_reg, dual;
  // Array is 64 KiB, so upper address bits fold back onto it
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  task automatic shift_in(input int n, input int w, output logic [31:0] v);
    v = 32'h0;
    repeat (n / w) begin
      @(posedge sck_i);
      v = (w == 2) ? {v[29:0], io_i[1:0]} : {v[30:0], io_i[0]};
    end
  endtask
  task automatic frame();
    logic [31:0] v;
    int          nb;
    if (!cont_reg) begin
      shift_in(8, 1, v);
      op_reg = v[7:0];
    end
    dual = op_reg == 8'hbb || op_reg == 8'hbc;
    nb = (op_reg == 8'h6c || op_reg == 8'hbc || ext_addr_i) ? 32 : 24;
    if (!dual && !(quad_en_i && (op_reg == 8'h6b || op_reg == 8'h6c))) return;
    shift_in(nb, dual ? 2 : 1, adr_reg);
    if (dual && enh_i) begin
      shift_in(8, 2, v);
      mode_reg = v[7:0];
    end
    repeat (dummy_i) @(posedge sck_i);
    forever begin
      v = {24'h0, mem_byte(adr_reg)};
      for (int i = dual ? 3 : 1; i >= 0; i--) begin
        @(negedge sck_i);
        io_oe_o = dual ? 4'h3 : 4'hf;
        io_o = dual ? {2'b00, v[2*i+:2]} : v[4*i+:4];
      end
      adr_reg = adr_reg + 32'h1;
    end
  endtask
  // One pass per select pulse; a cut frame keeps mode ff and so exits
  initial begin
    io_o = 4'h0;
    io_oe_o = 4'h0;
    cont_reg = 1'b0;
    dual = 1'b0;
    op_reg = 8'h00;
    forever begin
      @(negedge cs_n_i);
      mode_reg = 8'hff;
      fork : run
        frame();
        @(posedge cs_n_i);
      join_any
      disable run;
      if (!cs_n_i) @(posedge cs_n_i);
      io_oe_o = 4'h0;
      cont_reg = dual && enh_i && mode_reg[7:4] == 4'ha;
    end
  end
endmodule

/* verification/qdr_host_checker.sv */
// Port checker for the multi-line read host.
// Assumes the default register map and a bind onto every qdr_host.
`timescale 1ns/1ps
`include "qdr_defines.vh"
module qdr_host_checker #(
  parameter SCK_HALF = 3
) (
  input logic        clock_i,
  input logic        rst_i,
  input logic [3:0]  addr_i,
  input logic [31:0] wdata_i,
  input logic        wr_i,
  input logic        rd_i,
  input logic [31:0] rdata_o,
  input logic        busy_o,
  input logic        cs_n_o,
  input logic        sck_o,
  input logic [3:0]  io_o,
  input logic [3:0]  io_oe_o,
  input logic [3:0]  io_i
);
  // ----------------------------------------------------------------
  // Helper state and properties
  // ----------------------------------------------------------------
  logic [7:0] hi_cnt_reg;
  logic       qen_reg;
  logic       go;
  logic       go_quad;
  // Start writes only count while idle, as the host ignores them when busy
  assign go      = wr_i && addr_i == `QDR_REG_CTRL && wdata_i[0] && !wdata_i[4] && !busy_o;
  assign go_quad = go && !wdata_i[1];
  // High-phase length and a shadow of the quad enable bit
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hi_cnt_reg <= 8'h00;
      qen_reg    <= 1'b0;
    end else begin
      hi_cnt_reg <= sck_o ? hi_cnt_reg + 8'h01 : 8'h00;
      if (wr_i && addr_i == `QDR_REG_CONFIG && !busy_o) qen_reg <= wdata_i[1];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  AST_SCK_HALF: assert property ($fell(sck_o) |-> hi_cnt_reg == SCK_HALF + 1)
    else $error("serial clock high phase has the wrong length");
  AST_SCK_IN_FRAME: assert property (sck_o |-> !cs_n_o)
    else $error("serial clock runs outside a frame");
  AST_CS_SETUP: assert property ($fell(cs_n_o) |-> !sck_o ##1 !sck_o)
    else $error("select fell without clock setup");
  AST_IO_HOLD: assert property (sck_o && $past(sck_o) |-> $stable(io_o & io_oe_o))
    else $error("host line changed while clock high");
  AST_IO_SETUP: assert property ($rose(sck_o) |-> $stable(io_o & io_oe_o))
    else $error("host line changed with the rising serial clock");
  AST_START_FRAME: assert property (go && !(go_quad && !qen_reg) |=> !cs_n_o)
    else $error("start did not open a frame");
  AST_QUAD_REFUSED: assert property (go_quad && !qen_reg |=> cs_n_o [*8])
    else $error("quad read ran without quad enable");
  AST_BUSY_COVERS: assert property (!cs_n_o |-> busy_o)
    else $error("frame open while not busy");
  AST_CS_MIN_LOW: assert property ($fell(cs_n_o) |-> !cs_n_o [*8])
    else $error("select pulse too short");
  cover property (go && wdata_i[1]);
  cover property (go_quad && qen_reg);
  cover property (wr_i && addr_i == `QDR_REG_CTRL && wdata_i[4] && !busy_o);
endmodule
bind qdr_host qdr_host_checker #(.SCK_HALF(SCK_HALF)) chk_u (.clock_i(clock_i),
  .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .busy_o(busy_o), .cs_n_o(cs_n_o), .sck_o(sck_o), .io_o(io_o),
  .io_oe_o(io_oe_o), .io_i(io_i));

/* verification/qdr_host_tb_top.sv */
// Self-checking bench for the multi-line read host.
// Assumes the flash model on the far side of the resolved I/O lines.
`timescale 1ns/1ps
module qdr_host_tb_top;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  logic        clock_i, rst_i, wr_i, rd_i, busy_o, cs_n_o, sck_o, ext_m, qen_m, enh_m;
  logic [3:0]  addr_i, io_o, io_oe_o, dev_io, dev_oe, io_wire, dummy_m;
  logic [3:0]  float_reg = 4'h5;
  logic [31:0] wdata_i, rdata_o;
  int          mismatches, comparisons, cycles, frames;
  qdr_host #(.SCK_HALF(3)) dut_u (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o),
    .cs_n_o(cs_n_o), .sck_o(sck_o), .io_o(io_o), .io_oe_o(io_oe_o), .io_i(io_wire));
  qdr_flash_model flash_u (.cs_n_i(cs_n_o), .sck_i(sck_o), .io_i(io_wire),
    .ext_addr_i(ext_m), .quad_en_i(qen_m), .enh_i(enh_m), .dummy_i(dummy_m),
    .io_o(dev_io), .io_oe_o(dev_oe));
  // Undriven lines toggle so a stale level never reads back as data
  always @(posedge clock_i) float_reg <= ~float_reg;
  assign io_wire = (io_oe_o & io_o) | (~io_oe_o & dev_oe & dev_io)
                 | (~io_oe_o & ~dev_oe & float_reg);
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  // Hang guard and frame counter
  always @(posedge clock_i) begin
    cycles++;
    if (cycles > 40000) begin
      mismatches++;
      final_report();
    end
  end
  always @(negedge cs_n_o) frames++;
  task automatic final_report();
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h1;
    for (int k = 0; k < 3000 && s[0] !== 1'b0; k++) rd(4'h3, s);
    if (s[0] !== 1'b0) begin
      mismatches++;
      $display("Error at %0t: host stayed busy", $time);
    end
  endtask
  task automatic cfg(input logic e, input logic q, input logic h, input logic [3:0] dm);
    ext_m = e;
    qen_m = q;
    enh_m = h;
    dummy_m = dm;
    wr(4'h2, {24'h0, dm, 1'b0, h, q, e});
  endtask
  // Start a frame and compare every byte with the array pattern
  task automatic read_frame(input logic [31:0] ctrl, input logic [31:0] a, input int n);
    logic [31:0] s, d, x;
    wr(4'h1, a);
    wr(4'h0, {n[15:0], ctrl[15:1], 1'b1});
    for (int i = 0; i < n; i++) begin
      s = 32'h0;
      for (int k = 0; k < 400 && s[1] !== 1'b1; k++) rd(4'h3, s);
      if (s[1] !== 1'b1) begin
        mismatches++;
        $display("Error at %0t: no data byte arrived", $time);
      end
      rd(4'h4, d);
      x = a + i;
      chk({24'h0, d[7:0]}, {24'h0, x[7:0] ^ x[15:8] ^ 8'h3c});
    end
    wait_idle();
  endtask
  task automatic chk_cont(input logic v);
    logic [31:0] s;
    rd(4'h3, s);
    chk({31'h0, s[2]}, {31'h0, v});
  endtask
  task automatic t_quad();
    cfg(1'b0, 1'b1, 1'b0, 4'h8);
    read_frame(32'h0, 32'h0012fffe, 4);
    cfg(1'b0, 1'b1, 1'b0, 4'h0);
    read_frame(32'h4, 32'hab01fff0, 3);
  endtask
  task automatic t_refused();
    logic [31:0] s;
    int          f;
    cfg(1'b0, 1'b0, 1'b0, 4'h8);
    f = frames;
    wr(4'h0, 32'h00010001);
    wait_idle();
    rd(4'h3, s);
    chk({31'h0, s[3]}, 32'h1);
    chk(frames, f);
  endtask
  task automatic t_dual();
    cfg(1'b1, 1'b0, 1'b0, 4'h4);
    read_frame(32'h2, 32'h7654fffe, 3);
    cfg(1'b0, 1'b0, 1'b1, 4'h2);
    read_frame(32'ha, 32'h00001234, 2);
    chk_cont(1'b1);
    read_frame(32'ha, 32'h00400007, 2);
    read_frame(32'h2, 32'h00002222, 2);
    chk_cont(1'b0);
    read_frame(32'h6, 32'h00003333, 1);
    read_frame(32'ha, 32'h00004444, 1);
    wr(4'h0, 32'h00000010);
    wait_idle();
    chk_cont(1'b0);
    read_frame(32'h2, 32'h00005555, 2);
  endtask
  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    t_quad();
    t_refused();
    t_dual();
    final_report();
  end
endmodule
